// *** verilog/imd_pkg.sv ***
// shared types and constants of the integer multiply/divide unit
package imd_pkg;

    // ******************************************************************
    // timing, in pipeline clocks
    // ******************************************************************
    localparam int unsigned LAT_SHORT   = 3;
    localparam int unsigned LAT_LONG    = 4;
    localparam int unsigned REP_SHORT   = 2;
    localparam int unsigned REP_LONG    = 3;
    localparam int unsigned STALL_SHORT = 1;
    localparam int unsigned STALL_LONG  = 2;
    localparam int unsigned DIV_CYCLES  = 36;
    localparam int unsigned DIV_STEPS   = 32;
    localparam int unsigned CNT_W       = 6;
    localparam int unsigned NUM_SLOTS   = 2;

    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic [31:0] UPPER_RST  = 32'h0000_0000;
    localparam logic [31:0] BOTTOM_RST = 32'h0000_0000;

    // ******************************************************************
    // operations and carriers
    // ******************************************************************
    typedef enum logic [3:0] {
        signed_product_op,
        unsigned_product_op,
        product_accumulate_op,
        unsigned_accumulate_op,
        product_deduct_op,
        unsigned_deduct_op,
        product_to_gpr_op,
        signed_quotient_op,
        unsigned_quotient_op,
        read_upper_result_op,
        read_bottom_result_op
    } imd_op_t;

    typedef enum logic [1:0] {
        KIND_LOAD,
        KIND_ACCUM,
        KIND_DEDUCT,
        KIND_GPR
    } imd_kind_t;

    typedef struct packed {
        imd_op_t     op;
        logic [31:0] operand_a;
        logic [31:0] operand_b;
        logic [4:0]  dest;
    } imd_req_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  dest;
        logic [31:0] data;
    } imd_gpr_wr_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        imd_kind_t        kind;
        logic [4:0]       dest;
        logic [63:0]      prod;
    } imd_slot_t;

endpackage

// *** verilog/imd_divider.sv ***
// iterative 32-bit restoring divider, signed or unsigned
`timescale 1ns/1ps
module imd_divider (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic        signed_i,
    input  wire logic [31:0] dividend_i,
    input  wire logic [31:0] divisor_i,
    output logic      [31:0] quotient_o,
    output logic      [31:0] remainder_o
);

    // ******************************************************************
    // magnitude helper
    // ******************************************************************
    function automatic logic [31:0] mag(input logic [31:0] v, input logic sgn);
        mag = (sgn && v[31]) ? 32'(-v) : v;
    endfunction

    logic [31:0]                 quo_q;
    logic [31:0]                 rem_q;
    logic [31:0]                 dvs_q;
    logic [imd_pkg::CNT_W-1:0]   cnt_q;
    logic                        busy_q;
    logic                        qneg_q;
    logic                        rneg_q;
    logic [32:0]                 shifted;
    logic [32:0]                 diff;

    always_comb begin
        shifted = {rem_q, quo_q[31]};
        diff    = shifted - {1'b0, dvs_q};
    end

    // ******************************************************************
    // one quotient bit per clock; sign fix one clock after the last step
    // ******************************************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            quo_q       <= 32'h0000_0000;
            rem_q       <= 32'h0000_0000;
            dvs_q       <= 32'h0000_0000;
            cnt_q       <= '0;
            busy_q      <= 1'b0;
            qneg_q      <= 1'b0;
            rneg_q      <= 1'b0;
            quotient_o  <= 32'h0000_0000;
            remainder_o <= 32'h0000_0000;
        end else if (start_i) begin
            quo_q  <= mag(dividend_i, signed_i);
            dvs_q  <= mag(divisor_i, signed_i);
            rem_q  <= 32'h0000_0000;
            cnt_q  <= imd_pkg::CNT_W'(imd_pkg::DIV_STEPS);
            busy_q <= 1'b1;
            qneg_q <= signed_i && (dividend_i[31] ^ divisor_i[31]);
            rneg_q <= signed_i && dividend_i[31];
        end else if (busy_q && cnt_q != '0) begin
            if (!diff[32]) begin
                rem_q <= diff[31:0];
                quo_q <= {quo_q[30:0], 1'b1};
            end else begin
                rem_q <= shifted[31:0];
                quo_q <= {quo_q[30:0], 1'b0};
            end
            cnt_q <= cnt_q - 1'b1;
        end else if (busy_q) begin
            busy_q      <= 1'b0;
            quotient_o  <= qneg_q ? 32'(-quo_q) : quo_q;
            remainder_o <= rneg_q ? 32'(-rem_q) : rem_q;
        end
    end

endmodule

// *** verilog/imd_unit.sv ***
// integer multiply/divide unit with result register pair and interlocks
`timescale 1ns/1ps
module imd_unit (
    input  wire logic                 clock_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 req_valid_i,
    input  wire imd_pkg::imd_req_t    req_i,
    output logic                      issue_ready_o,
    output logic                      result_ready_o,
    output logic                      stall_o,
    output imd_pkg::imd_gpr_wr_t      gpr_wr_o,
    output logic [31:0]               upper_result_o,
    output logic [31:0]               bottom_result_o
);

    // ******************************************************************
    // helpers
    // ******************************************************************
    function automatic logic fits16(input logic [31:0] v, input logic sgn);
        fits16 = sgn ? (v[31:15] == {17{v[15]}}) : (v[31:16] == 16'h0000);
    endfunction

    function automatic logic [imd_pkg::CNT_W-1:0] cnt(input int unsigned v);
        cnt = imd_pkg::CNT_W'(v);
    endfunction

    // ******************************************************************
    // request decode
    // ******************************************************************
    logic                        is_mul;
    logic                        is_div;
    logic                        is_read;
    logic                        sgn;
    logic                        short_ops;
    logic                        take;
    logic [65:0]                 product;
    imd_pkg::imd_kind_t          kind;
    logic [imd_pkg::CNT_W-1:0]   lat;
    logic [imd_pkg::CNT_W-1:0]   rep;

    logic [31:0]                 upper_result_reg;
    logic [31:0]                 bottom_result_reg;
    imd_pkg::imd_slot_t          slot_q [imd_pkg::NUM_SLOTS];
    logic                        next_slot_q;
    logic [imd_pkg::CNT_W-1:0]   div_cnt_q;
    logic [imd_pkg::CNT_W-1:0]   rep_cnt_q;
    logic [imd_pkg::CNT_W-1:0]   rep_cnt_d;
    logic [1:0]                  stall_cnt_q;
    logic [1:0]                  stall_cnt_d;
    logic                        pending_d;
    logic [31:0]                 div_quo;
    logic [31:0]                 div_rem;

    always_comb begin
        is_mul  = 1'b0;
        is_div  = 1'b0;
        is_read = 1'b0;
        sgn     = 1'b1;
        kind    = imd_pkg::KIND_LOAD;
        unique case (req_i.op)
            imd_pkg::signed_product_op:      is_mul = 1'b1;
            imd_pkg::unsigned_product_op: begin
                is_mul = 1'b1;
                sgn    = 1'b0;
            end
            imd_pkg::product_accumulate_op: begin
                is_mul = 1'b1;
                kind   = imd_pkg::KIND_ACCUM;
            end
            imd_pkg::unsigned_accumulate_op: begin
                is_mul = 1'b1;
                sgn    = 1'b0;
                kind   = imd_pkg::KIND_ACCUM;
            end
            imd_pkg::product_deduct_op: begin
                is_mul = 1'b1;
                kind   = imd_pkg::KIND_DEDUCT;
            end
            imd_pkg::unsigned_deduct_op: begin
                is_mul = 1'b1;
                sgn    = 1'b0;
                kind   = imd_pkg::KIND_DEDUCT;
            end
            imd_pkg::product_to_gpr_op: begin
                is_mul = 1'b1;
                kind   = imd_pkg::KIND_GPR;
            end
            imd_pkg::signed_quotient_op:     is_div = 1'b1;
            imd_pkg::unsigned_quotient_op: begin
                is_div = 1'b1;
                sgn    = 1'b0;
            end
            imd_pkg::read_upper_result_op,
            imd_pkg::read_bottom_result_op:  is_read = 1'b1;
            default: ;
        endcase
        // size detection picks latency and repeat with no software hint
        short_ops = fits16(req_i.operand_a, sgn) && fits16(req_i.operand_b, sgn);
        lat       = short_ops ? cnt(imd_pkg::LAT_SHORT) : cnt(imd_pkg::LAT_LONG);
        rep       = short_ops ? cnt(imd_pkg::REP_SHORT) : cnt(imd_pkg::REP_LONG);
        // unsigned variants zero-extend, signed ones sign-extend
        product   = $signed({sgn & req_i.operand_a[31], req_i.operand_a})
                  * $signed({sgn & req_i.operand_b[31], req_i.operand_b});
        // a request is held off while an interlock or fixed stall stands
        take      = req_valid_i && !stall_o
                  && ((is_mul || is_div) ? issue_ready_o : (is_read && result_ready_o));
    end

    // ******************************************************************
    // repeat-rate and fixed-stall counters
    // ******************************************************************
    always_comb begin
        rep_cnt_d   = (rep_cnt_q != '0) ? rep_cnt_q - 1'b1 : rep_cnt_q;
        stall_cnt_d = (stall_cnt_q != 2'h0) ? stall_cnt_q - 2'h1 : stall_cnt_q;
        if (take && is_mul) begin
            rep_cnt_d = rep - 1'b1;
        end
        if (take && is_div) begin
            rep_cnt_d = cnt(imd_pkg::DIV_CYCLES - 1);
        end
        if (take && req_i.op == imd_pkg::product_to_gpr_op) begin
            stall_cnt_d = short_ops ? 2'(imd_pkg::STALL_SHORT) : 2'(imd_pkg::STALL_LONG);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rep_cnt_q     <= '0;
            stall_cnt_q   <= 2'h0;
            issue_ready_o <= 1'b1;
            stall_o       <= 1'b0;
        end else begin
            rep_cnt_q     <= rep_cnt_d;
            stall_cnt_q   <= stall_cnt_d;
            issue_ready_o <= (rep_cnt_d == '0);
            stall_o       <= (stall_cnt_d != 2'h0);
        end
    end

    // ******************************************************************
    // multiply slots: two in flight at most
    // ******************************************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            next_slot_q <= 1'b0;
            for (int i = 0; i < imd_pkg::NUM_SLOTS; i++) begin
                slot_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < imd_pkg::NUM_SLOTS; i++) begin
                if (slot_q[i].cnt != '0) begin
                    slot_q[i].cnt <= slot_q[i].cnt - 1'b1;
                end
            end
            if (take && is_mul) begin
                // the other slot may still hold an earlier product
                slot_q[next_slot_q] <= '{cnt: lat, kind: kind, dest: req_i.dest,
                                         prod: product[63:0]};
                next_slot_q         <= ~next_slot_q;
            end
        end
    end

    // ******************************************************************
    // divide sequencing
    // ******************************************************************
    imd_divider u_divider (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .start_i     (take && is_div),
        .signed_i    (sgn),
        .dividend_i  (req_i.operand_a),
        .divisor_i   (req_i.operand_b),
        .quotient_o  (div_quo),
        .remainder_o (div_rem)
    );

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            div_cnt_q <= '0;
        end else if (take && is_div) begin
            div_cnt_q <= cnt(imd_pkg::DIV_CYCLES);
        end else if (div_cnt_q != '0) begin
            div_cnt_q <= div_cnt_q - 1'b1;
        end
    end

    // ******************************************************************
    // result register pair; completions never coincide
    // ******************************************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            upper_result_reg  <= imd_pkg::UPPER_RST;
            bottom_result_reg <= imd_pkg::BOTTOM_RST;
        end else begin
            for (int i = 0; i < imd_pkg::NUM_SLOTS; i++) begin
                if (slot_q[i].cnt == cnt(1)) begin
                    unique case (slot_q[i].kind)
                        imd_pkg::KIND_LOAD:
                            {upper_result_reg, bottom_result_reg} <= slot_q[i].prod;
                        imd_pkg::KIND_ACCUM:
                            {upper_result_reg, bottom_result_reg} <=
                                {upper_result_reg, bottom_result_reg} + slot_q[i].prod;
                        imd_pkg::KIND_DEDUCT:
                            {upper_result_reg, bottom_result_reg} <=
                                {upper_result_reg, bottom_result_reg} - slot_q[i].prod;
                        imd_pkg::KIND_GPR: ;
                    endcase
                end
            end
            if (div_cnt_q == cnt(1)) begin
                upper_result_reg  <= div_rem;
                bottom_result_reg <= div_quo;
            end
        end
    end

    // ******************************************************************
    // general register writes and result-read interlock
    // ******************************************************************
    always_comb begin
        pending_d = (div_cnt_q > cnt(1)) || (take && (is_mul || is_div));
        for (int i = 0; i < imd_pkg::NUM_SLOTS; i++) begin
            if (slot_q[i].cnt > cnt(1)) begin
                pending_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            gpr_wr_o       <= '0;
            result_ready_o <= 1'b1;
        end else begin
            result_ready_o <= !pending_d;
            gpr_wr_o.valid <= 1'b0;
            for (int i = 0; i < imd_pkg::NUM_SLOTS; i++) begin
                if (slot_q[i].cnt == cnt(1) && slot_q[i].kind == imd_pkg::KIND_GPR) begin
                    gpr_wr_o <= '{valid: 1'b1, dest: slot_q[i].dest,
                                  data: slot_q[i].prod[31:0]};
                end
            end
            if (take && is_read) begin
                gpr_wr_o <= '{valid: 1'b1, dest: req_i.dest,
                              data: (req_i.op == imd_pkg::read_upper_result_op)
                                    ? upper_result_reg : bottom_result_reg};
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            upper_result_o  <= imd_pkg::UPPER_RST;
            bottom_result_o <= imd_pkg::BOTTOM_RST;
        end else begin
            upper_result_o  <= upper_result_reg;
            bottom_result_o <= bottom_result_reg;
        end
    end

endmodule

// *** verification/imd_unit_monitor.sv ***
// assertion checker on the ports of the integer multiply/divide unit
`timescale 1ns/1ps
module imd_unit_monitor (
    input wire logic                 clock_i,
    input wire logic                 rst_n_i,
    input wire logic                 req_valid_i,
    input wire imd_pkg::imd_req_t    req_i,
    input wire logic                 issue_ready_o,
    input wire logic                 result_ready_o,
    input wire logic                 stall_o,
    input wire imd_pkg::imd_gpr_wr_t gpr_wr_o,
    input wire logic [31:0]          upper_result_o,
    input wire logic [31:0]          bottom_result_o
);
    logic        mv, md, ml, gp, sg, sh, tk;
    logic [31:0] a, b, pl;
    always_comb begin
        a  = req_i.operand_a;
        b  = req_i.operand_b;
        pl = a * b;
        mv = req_i.op inside {imd_pkg::read_upper_result_op, imd_pkg::read_bottom_result_op};
        md = req_i.op <= imd_pkg::unsigned_quotient_op;
        ml = req_i.op < imd_pkg::signed_quotient_op;
        gp = req_i.op == imd_pkg::product_to_gpr_op;
        sg = req_i.op inside {imd_pkg::signed_product_op, imd_pkg::product_accumulate_op,
                              imd_pkg::product_deduct_op, imd_pkg::product_to_gpr_op};
        // both operands fit 16 bits, sign- or zero-extended
        sh = sg ? ((&a[31:15] || ~|a[31:15]) && (&b[31:15] || ~|b[31:15])) : ~|{a[31:16], b[31:16]};
        tk = req_valid_i && !stall_o && (md ? issue_ready_o : mv && result_ready_o);
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // ******************************************************************
    // assertions
    // ******************************************************************
    a_short_repeat: assert property (tk && ml && sh |=> !issue_ready_o ##1 issue_ready_o)
        else $error("issue ready wrong after 16-bit multiply");
    a_long_repeat: assert property (tk && ml && !sh |=> !issue_ready_o[*2] ##1 issue_ready_o)
        else $error("issue ready wrong after 32-bit multiply");
    a_div_repeat: assert property (tk && md && !ml |=> !issue_ready_o ##34 !issue_ready_o ##1 issue_ready_o)
        else $error("issue ready wrong after divide");
    a_short_pending: assert property (tk && ml && sh |=> !result_ready_o[*3])
        else $error("result ready too early after 16-bit multiply");
    a_long_pending: assert property (tk && ml && !sh |=> !result_ready_o[*4])
        else $error("result ready too early after 32-bit multiply");
    a_stall_short: assert property (tk && gp && sh |=> stall_o ##1 !stall_o)
        else $error("stall length wrong for 16-bit gpr multiply");
    a_stall_long: assert property (tk && gp && !sh |=> stall_o[*2] ##1 !stall_o)
        else $error("stall length wrong for 32-bit gpr multiply");
    a_no_stall: assert property (tk && !gp |=> !stall_o)
        else $error("stall raised by an operation without fixed stall");
    a_gpr_product: assert property (tk && gp && sh |-> ##4 (gpr_wr_o.valid && gpr_wr_o.data == $past(pl, 4)))
        else $error("gpr product write missing or wrong");
    a_gpr_long: assert property (tk && gp && !sh |-> ##5 (gpr_wr_o.valid && gpr_wr_o.data == $past(pl, 5)))
        else $error("32-bit gpr product write missing or wrong");
    a_div_pending: assert property (tk && md && !ml |=> !result_ready_o ##35 !result_ready_o)
        else $error("result ready too early after divide");
    a_move_upper: assert property (tk && req_i.op == imd_pkg::read_upper_result_op |=>
        ##[0:1] (gpr_wr_o.valid && gpr_wr_o.data == upper_result_o))
        else $error("upper move does not carry the upper result");
    a_move_bottom: assert property (tk && req_i.op == imd_pkg::read_bottom_result_op |=>
        ##[0:1] (gpr_wr_o.valid && gpr_wr_o.data == bottom_result_o))
        else $error("bottom move does not carry the bottom result");
endmodule

bind imd_unit imd_unit_monitor i_imd_unit_monitor (
    .clock_i         (clock_i),
    .rst_n_i         (rst_n_i),
    .req_valid_i     (req_valid_i),
    .req_i           (req_i),
    .issue_ready_o   (issue_ready_o),
    .result_ready_o  (result_ready_o),
    .stall_o         (stall_o),
    .gpr_wr_o        (gpr_wr_o),
    .upper_result_o  (upper_result_o),
    .bottom_result_o (bottom_result_o)
);

// *** verification/imd_issuer.sv ***
// issue pipeline model: presents requests and holds them until taken
`timescale 1ns/1ps
module imd_issuer (
    input  wire logic         clock_i,
    input  wire logic         issue_ready_i,
    input  wire logic         result_ready_i,
    input  wire logic         stall_i,
    output logic              req_valid_o,
    output imd_pkg::imd_req_t req_o
);
    int waited;
    initial begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end
    // request held steady from a falling edge up to the edge that takes it
    task automatic issue(input imd_pkg::imd_req_t r, input int limit);
        logic mv;
        logic md;
        @(negedge clock_i);
        req_valid_o = 1'b1;
        req_o       = r;
        mv = r.op inside {imd_pkg::read_upper_result_op, imd_pkg::read_bottom_result_op};
        md = r.op <= imd_pkg::unsigned_quotient_op;
        waited = 0;
        while (waited < limit) begin
            @(posedge clock_i);
            waited++;
            if (!stall_i && (md ? issue_ready_i : mv && result_ready_i)) return;
        end
        waited = 0;
    endtask
    // released request fields show the inverse of the last value
    task automatic idle;
        @(negedge clock_i);
        req_valid_o = 1'b0;
        req_o       = ~req_o;
    endtask
endmodule

// *** verification/imd_unit_test.sv ***
// self-checking bench of the integer multiply/divide unit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module imd_unit_test;
    logic                 clock_i = 1'b0;
    logic                 rst_n_i = 1'b0;
    logic                 req_valid_i;
    imd_pkg::imd_req_t    req_i;
    logic                 issue_ready_o, result_ready_o, stall_o;
    imd_pkg::imd_gpr_wr_t gpr_wr_o, e;
    logic [31:0]          upper_result_o, bottom_result_o, hi, lo, seed = 32'hd8c8;
    imd_pkg::imd_gpr_wr_t exp_q[$];
    imd_pkg::imd_op_t     ops[9] = '{imd_pkg::signed_product_op, imd_pkg::unsigned_product_op,
        imd_pkg::product_accumulate_op, imd_pkg::unsigned_accumulate_op, imd_pkg::product_deduct_op,
        imd_pkg::unsigned_deduct_op, imd_pkg::product_to_gpr_op, imd_pkg::signed_quotient_op,
        imd_pkg::unsigned_quotient_op};
    int                   fails = 0, checked = 0;
    always #25 clock_i = ~clock_i;
    imd_unit i_imd_unit (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .issue_ready_o(issue_ready_o), .result_ready_o(result_ready_o), .stall_o(stall_o),
        .gpr_wr_o(gpr_wr_o), .upper_result_o(upper_result_o), .bottom_result_o(bottom_result_o));
    imd_issuer i_imd_issuer (.clock_i(clock_i), .issue_ready_i(issue_ready_o), .result_ready_i(result_ready_o),
        .stall_i(stall_o), .req_valid_o(req_valid_i), .req_o(req_i));
    // ******************************************************************
    // stimulus helpers and reference model
    // ******************************************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] opnd(input logic sg, input logic sh);
        logic [31:0] r;
        r = xs();
        if (sh) return sg ? {{16{r[15]}}, r[15:0]} : {16'h0000, r[15:0]};
        return {r[31], ~r[31], r[29:0]};
    endfunction
    task automatic send(input imd_pkg::imd_op_t op, input logic sh, input int limit);
        logic [31:0] a, b;
        logic [63:0] ps, pu;
        logic [4:0]  d;
        logic        sg;
        sg = op inside {imd_pkg::signed_product_op, imd_pkg::product_accumulate_op,
                        imd_pkg::product_deduct_op, imd_pkg::product_to_gpr_op, imd_pkg::signed_quotient_op};
        a = opnd(sg, sh);
        b = opnd(sg, sh);
        if (b == 32'h0000_0000) b = 32'h0000_0001;
        d = 5'(xs());
        ps = $signed(a) * $signed(b);
        pu = a * b;
        case (op)
            imd_pkg::signed_product_op:      {hi, lo} = ps;
            imd_pkg::unsigned_product_op:    {hi, lo} = pu;
            imd_pkg::product_accumulate_op:  {hi, lo} = {hi, lo} + ps;
            imd_pkg::unsigned_accumulate_op: {hi, lo} = {hi, lo} + pu;
            imd_pkg::product_deduct_op:      {hi, lo} = {hi, lo} - ps;
            imd_pkg::unsigned_deduct_op:     {hi, lo} = {hi, lo} - pu;
            imd_pkg::product_to_gpr_op:      exp_q.push_back({1'b1, d, ps[31:0]});
            imd_pkg::signed_quotient_op: begin
                lo = $signed(a) / $signed(b);
                hi = $signed(a) % $signed(b);
            end
            imd_pkg::unsigned_quotient_op: begin
                lo = a / b;
                hi = a % b;
            end
            imd_pkg::read_upper_result_op:   exp_q.push_back({1'b1, d, hi});
            imd_pkg::read_bottom_result_op:  exp_q.push_back({1'b1, d, lo});
            default: ;
        endcase
        i_imd_issuer.issue('{op: op, operand_a: a, operand_b: b, dest: d}, limit);
    endtask
    task automatic wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ******************************************************************
    // result watcher
    // ******************************************************************
    always @(negedge clock_i) begin
        if (gpr_wr_o.valid !== 1'b0) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("ERROR gpr write expected none seen %h", gpr_wr_o);
            end else begin
                e = exp_q.pop_front();
                `CHK("gpr write", e, gpr_wr_o)
            end
        end
    end
    // ******************************************************************
    // main sequence
    // ******************************************************************
    initial begin
        hi = 32'h0000_0000;
        lo = 32'h0000_0000;
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        foreach (ops[i]) begin
            for (int s = 0; s < 2; s++) begin
                send(ops[i], s == 0, 64);
                `CHK("first wait", 1, i_imd_issuer.waited)
                send(ops[i], s == 0, 64);
                `CHK("repeat wait", i > 6 ? 36 : (s == 0 ? 2 : 3), i_imd_issuer.waited)
                send(imd_pkg::read_upper_result_op, 1'b0, 64);
                `CHK("move wait", i > 6 ? 37 : (s == 0 ? 4 : 5), i_imd_issuer.waited)
                send(imd_pkg::read_bottom_result_op, 1'b0, 64);
                `CHK("back to back move", 1, i_imd_issuer.waited)
                i_imd_issuer.idle();
                `CHK("upper result", hi, upper_result_o)
                `CHK("bottom result", lo, bottom_result_o)
            end
        end
        send(imd_pkg::imd_op_t'(4'hf), 1'b0, 8);
        `CHK("unknown op taken", 0, i_imd_issuer.waited)
        i_imd_issuer.idle();
        send(imd_pkg::signed_product_op, 1'b0, 8);
        i_imd_issuer.idle();
        rst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        hi = imd_pkg::UPPER_RST;
        lo = imd_pkg::BOTTOM_RST;
        send(imd_pkg::read_upper_result_op, 1'b0, 8);
        `CHK("move after reset", 1, i_imd_issuer.waited)
        send(imd_pkg::read_bottom_result_op, 1'b0, 8);
        i_imd_issuer.idle();
        repeat (10) @(negedge clock_i);
        `CHK("pending writes", 0, exp_q.size())
        `CHK("upper after reset", imd_pkg::UPPER_RST, upper_result_o)
        `CHK("bottom after reset", imd_pkg::BOTTOM_RST, bottom_result_o)
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        fails++;
        wrap_up();
    end
endmodule
